/* e1tx_config_regs.sv */
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
// What this block does
// - The 4-bit select picks one of sixteen counter bytes for the data register.
// - Select codes map to CRC, frame, alignment, out-of-frame, pattern, violation, far-end counts.
// - Data register is read-only, resets to zero, shows the selected byte.
// - Receive mux bit: 0 non-multiplexed, 1 multiplexed; resets to 0.
// - Transmit mux bit: 0 non-multiplexed, 1 multiplexed; resets to 0.
// - With peak hold off, the indicator tracks the live pointer gap.
// - With peak hold on, the indicator keeps the largest gap seen.
// - Limit bit widens bandwidth near FIFO edges; normal bandwidth when 0.
// - Attenuator runs only when enabled, bypassed otherwise; resets disabled.
// - Depth code 00 gives 128, 01 gives 64, else 32 bits.
// - Bandwidth bit: 0 selects 6.77 Hz corner, 1 selects 0.87 Hz.
// - Power-off bit powers down transmit path and tristates the driver.
// - Line code bit: 0 HDB3 encoder, 1 AMI encoder.
// - Driver failure monitor runs only when its bit is 1; resets 0.
// - Driver tristate bit, reset 1, floats only the driver.
// - Template code 0000, 0001 fixed shapes, 11xx arbitrary, others reserved.
// - Amplitude scale acts only for arbitrary waveform; 100001 is standard.
// - Any write to the reset register restores all registers to defaults.
module e1tx_config_regs
	import e1tx_pkg::*;
#(
	parameter int ADDR_W = 10
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] crc_error_count,
	input wire logic [15:0] frame_error_count,
	input wire logic [7:0] alignment_change_count,
	input wire logic [7:0] out_of_frame_count,
	input wire logic [15:0] pattern_detector_count,
	input wire logic [15:0] code_violation_count,
	input wire logic [15:0] tx_crc_error_count,
	input wire logic [15:0] far_block_error_count,
	input wire logic [15:0] tx_far_block_error_count,
	input wire logic [6:0] tx_fifo_pointer_gap,
	output logic rx_backplane_muxed,
	output logic tx_backplane_muxed,
	output logic atten_enable,
	output logic [1:0] atten_depth,
	output logic atten_bandwidth,
	output logic atten_widen_near_limit,
	output logic jitter_peak_hold_sel,
	output logic atten_widened,
	output logic tx_path_power_down,
	output logic tx_line_code_sel,
	output logic driver_monitor_enable,
	output logic driver_tristate,
	output logic line_driver_hiz,
	output logic [3:0] pulse_template_sel,
	output logic template_arbitrary,
	output logic [5:0] amplitude_scale,
	output logic [5:0] amplitude_scale_applied
);

	logic [7:0] idx;
	logic aligned;
	logic hit;
	logic wr_go;
	logic sw_reset;
	logic [31:0] rd_word;
	logic [3:0] window_select_q;
	logic [7:0] window_value;
	logic rx_mux_q;
	logic tx_mux_q;
	logic peak_hold_q;
	logic widen_q;
	logic atten_en_q;
	logic [1:0] depth_q;
	logic bandwidth_q;
	logic tx_off_q;
	logic line_code_q;
	logic drv_mon_q;
	logic drv_hiz_q;
	logic [3:0] template_q;
	logic [5:0] scale_q;
	logic [6:0] gap_indicator;
	logic hiz_out_q;
	logic arb_q;
	logic [5:0] scale_applied_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;

	// Decode of the mapped indices, shared by write strobe and error flag
	function automatic logic is_mapped(input logic [7:0] i);
		is_mapped = (i == IDX_SOFT_RESET) || (i == IDX_WINDOW_SELECT)
			|| (i == IDX_WINDOW_DATA) || (i == IDX_BACKPLANE)
			|| (i == IDX_JITTER_CFG) || (i == IDX_TX_PATH)
			|| (i == IDX_TX_DRIVER) || (i == IDX_TX_SCALE)
			|| (i == IDX_JITTER_IND);
	endfunction

	// Word index from the byte address; high address bits must be zero
	always_comb
	begin
		idx = 8'h00;
		idx[ADDR_W-3:0] = paddr[ADDR_W-1:2];
	end
	assign aligned = (paddr[1:0] == 2'b00);
	assign hit = aligned && is_mapped(idx);

	// Writes land on the edge that completes the access phase
	assign wr_go = psel && penable && pready_q && pwrite && hit;
	// any value written here restores defaults
	assign sw_reset = wr_go && (idx == IDX_SOFT_RESET);

	// Answer one cycle into the access phase, always from flops; unmapped gets an error
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end
		else
		begin
			pready_q <= psel && penable && !pready_q;
			pslverr_q <= psel && penable && !pready_q && !hit;
			if (psel && penable && !pready_q && !pwrite)
				prdata_q <= rd_word;
		end
	end

	// read mux, reserved and unused bits are zero
	always_comb
	begin
		rd_word = 32'h0000_0000;
		unique case (idx)
			IDX_WINDOW_SELECT:
				rd_word[3:0] = window_select_q;
			IDX_WINDOW_DATA:
				rd_word[7:0] = window_value;
			IDX_BACKPLANE:
			begin
				rd_word[BIT_RX_MUX] = rx_mux_q;
				rd_word[BIT_TX_MUX] = tx_mux_q;
			end
			IDX_JITTER_CFG:
			begin
				rd_word[BIT_PEAK_HOLD] = peak_hold_q;
				rd_word[BIT_WIDEN] = widen_q;
				rd_word[BIT_ATTEN_EN] = atten_en_q;
				rd_word[BIT_DEPTH_LO +: 2] = depth_q;
				rd_word[BIT_BANDWIDTH] = bandwidth_q;
			end
			IDX_TX_PATH:
			begin
				rd_word[BIT_TX_OFF] = tx_off_q;
				rd_word[BIT_LINE_CODE] = line_code_q;
			end
			IDX_TX_DRIVER:
			begin
				rd_word[BIT_DRV_MON] = drv_mon_q;
				rd_word[BIT_DRV_HIZ] = drv_hiz_q;
				rd_word[3:0] = template_q;
			end
			IDX_TX_SCALE:
				rd_word[5:0] = scale_q;
			IDX_JITTER_IND:
				rd_word[6:0] = gap_indicator;
			default:
				rd_word = 32'h0000_0000;
		endcase
		if (!aligned)
			rd_word = 32'h0000_0000;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			window_select_q <= RST_WINDOW_SELECT;
		else if (sw_reset)
			window_select_q <= RST_WINDOW_SELECT;
		else if (wr_go && idx == IDX_WINDOW_SELECT)
			window_select_q <= pwdata[3:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_mux_q <= 1'b0;
			tx_mux_q <= 1'b0;
		end
		else if (sw_reset)
		begin
			rx_mux_q <= 1'b0;
			tx_mux_q <= 1'b0;
		end
		else if (wr_go && idx == IDX_BACKPLANE)
		begin
			rx_mux_q <= pwdata[BIT_RX_MUX];
			tx_mux_q <= pwdata[BIT_TX_MUX];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			peak_hold_q <= 1'b0;
			widen_q <= 1'b0;
			atten_en_q <= 1'b0;
			depth_q <= RST_DEPTH;
			bandwidth_q <= 1'b0;
		end
		else if (sw_reset)
		begin
			peak_hold_q <= 1'b0;
			widen_q <= 1'b0;
			atten_en_q <= 1'b0;
			depth_q <= RST_DEPTH;
			bandwidth_q <= 1'b0;
		end
		else if (wr_go && idx == IDX_JITTER_CFG)
		begin
			peak_hold_q <= pwdata[BIT_PEAK_HOLD];
			widen_q <= pwdata[BIT_WIDEN];
			atten_en_q <= pwdata[BIT_ATTEN_EN];
			depth_q <= pwdata[BIT_DEPTH_LO +: 2];
			bandwidth_q <= pwdata[BIT_BANDWIDTH];
		end
	end

	// transmit path power and line code
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_off_q <= 1'b0;
			line_code_q <= 1'b0;
		end
		else if (sw_reset)
		begin
			tx_off_q <= 1'b0;
			line_code_q <= 1'b0;
		end
		else if (wr_go && idx == IDX_TX_PATH)
		begin
			tx_off_q <= pwdata[BIT_TX_OFF];
			line_code_q <= pwdata[BIT_LINE_CODE];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			drv_mon_q <= 1'b0;
			drv_hiz_q <= RST_DRV_HIZ;
			template_q <= RST_TEMPLATE;
		end
		else if (sw_reset)
		begin
			drv_mon_q <= 1'b0;
			drv_hiz_q <= RST_DRV_HIZ;
			template_q <= RST_TEMPLATE;
		end
		else if (wr_go && idx == IDX_TX_DRIVER)
		begin
			drv_mon_q <= pwdata[BIT_DRV_MON];
			drv_hiz_q <= pwdata[BIT_DRV_HIZ];
			template_q <= pwdata[3:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			scale_q <= RST_SCALE;
		else if (sw_reset)
			scale_q <= RST_SCALE;
		else if (wr_go && idx == IDX_TX_SCALE)
			scale_q <= pwdata[5:0];
	end

	// driver floats when powered off or tristated by software
	// scaling reaches the DAC only for the arbitrary template
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			hiz_out_q <= 1'b1;
			arb_q <= 1'b0;
			scale_applied_q <= SCALE_STANDARD;
		end
		else
		begin
			hiz_out_q <= tx_off_q || drv_hiz_q;
			arb_q <= (template_q[3:2] == TEMPLATE_ARB_TOP);
			scale_applied_q <= (template_q[3:2] == TEMPLATE_ARB_TOP) ? scale_q : SCALE_STANDARD;
		end
	end

	// byte refreshed every cycle, so the next read already sees it
	e1tx_window_mux u_window
	(
		.pclk(pclk),
		.presetn(presetn),
		.clear(sw_reset),
		.window_select(window_select_q),
		.crc_error_count(crc_error_count),
		.frame_error_count(frame_error_count),
		.alignment_change_count(alignment_change_count),
		.out_of_frame_count(out_of_frame_count),
		.pattern_detector_count(pattern_detector_count),
		.code_violation_count(code_violation_count),
		.tx_crc_error_count(tx_crc_error_count),
		.far_block_error_count(far_block_error_count),
		.tx_far_block_error_count(tx_far_block_error_count),
		.window_value(window_value)
	);

	// Indicator keeps tracking even when bypassed, so software can size depth
	e1tx_jitter_track u_jitter
	(
		.pclk(pclk),
		.presetn(presetn),
		.clear(sw_reset),
		.atten_enable(atten_en_q),
		.peak_hold(peak_hold_q),
		.widen_allowed(widen_q),
		.depth(depth_q),
		.pointer_gap(tx_fifo_pointer_gap),
		.pointer_gap_indicator(gap_indicator),
		.widened(atten_widened)
	);

	// Outputs, each from a flop
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign rx_backplane_muxed = rx_mux_q;
	assign tx_backplane_muxed = tx_mux_q;
	assign atten_enable = atten_en_q;
	assign atten_depth = depth_q;
	assign atten_bandwidth = bandwidth_q;
	assign atten_widen_near_limit = widen_q;
	assign jitter_peak_hold_sel = peak_hold_q;
	assign tx_path_power_down = tx_off_q;
	assign tx_line_code_sel = line_code_q;
	assign driver_monitor_enable = drv_mon_q;
	assign driver_tristate = drv_hiz_q;
	assign line_driver_hiz = hiz_out_q;
	assign pulse_template_sel = template_q;
	assign template_arbitrary = arb_q;
	assign amplitude_scale = scale_q;
	assign amplitude_scale_applied = scale_applied_q;

endmodule

/* e1tx_pkg.sv */
package e1tx_pkg;

	// Register indices; the byte address on the bus is four times the index
	localparam logic [7:0] IDX_SOFT_RESET = 8'h04;
	localparam logic [7:0] IDX_WINDOW_SELECT = 8'h0e;
	localparam logic [7:0] IDX_WINDOW_DATA = 8'h0f;
	localparam logic [7:0] IDX_BACKPLANE = 8'h10;
	localparam logic [7:0] IDX_JITTER_CFG = 8'h21;
	localparam logic [7:0] IDX_TX_PATH = 8'h22;
	localparam logic [7:0] IDX_TX_DRIVER = 8'h23;
	localparam logic [7:0] IDX_TX_SCALE = 8'h24;
	localparam logic [7:0] IDX_JITTER_IND = 8'h38;

	// Field positions
	localparam int BIT_RX_MUX = 3;
	localparam int BIT_TX_MUX = 0;
	localparam int BIT_PEAK_HOLD = 5;
	localparam int BIT_WIDEN = 4;
	localparam int BIT_ATTEN_EN = 3;
	localparam int BIT_DEPTH_LO = 1;
	localparam int BIT_BANDWIDTH = 0;
	localparam int BIT_TX_OFF = 4;
	localparam int BIT_LINE_CODE = 0;
	localparam int BIT_DRV_MON = 5;
	localparam int BIT_DRV_HIZ = 4;

	// Values after reset
	localparam logic [3:0] RST_WINDOW_SELECT = 4'h0;
	localparam logic [1:0] RST_DEPTH = 2'h0;
	localparam logic RST_DRV_HIZ = 1'b1;
	localparam logic [3:0] RST_TEMPLATE = 4'h0;
	localparam logic [5:0] RST_SCALE = 6'h21;
	localparam logic [6:0] RST_INDICATOR = 7'h00;

	// Template codes; the top two bits set means arbitrary waveform
	localparam logic [1:0] TEMPLATE_ARB_TOP = 2'h3;
	localparam logic [5:0] SCALE_STANDARD = 6'h21;

	// Attenuator FIFO depths in bits and their guard margins
	localparam logic [1:0] DEPTH_CODE_128 = 2'h0;
	localparam logic [1:0] DEPTH_CODE_64 = 2'h1;
	localparam logic [7:0] DEPTH_128 = 8'h80;
	localparam logic [7:0] DEPTH_64 = 8'h40;
	localparam logic [7:0] DEPTH_32 = 8'h20;
	localparam logic [7:0] MARGIN_128 = 8'h04;
	localparam logic [7:0] MARGIN_64 = 8'h03;
	localparam logic [7:0] MARGIN_32 = 8'h02;

	// Bus access state
	typedef enum logic [1:0] {
		E1TX_IDLE = 2'b00,
		E1TX_WAIT = 2'b01,
		E1TX_DONE = 2'b10
	} e1tx_bus_state_t;

endpackage

/* e1tx_window_mux.sv */
`timescale 1ns/1ps
// Picks one performance monitor byte; mapping 0 of a pair is the low byte
module e1tx_window_mux
	import e1tx_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clear,
	input wire logic [3:0] window_select,
	input wire logic [15:0] crc_error_count,
	input wire logic [15:0] frame_error_count,
	input wire logic [7:0] alignment_change_count,
	input wire logic [7:0] out_of_frame_count,
	input wire logic [15:0] pattern_detector_count,
	input wire logic [15:0] code_violation_count,
	input wire logic [15:0] tx_crc_error_count,
	input wire logic [15:0] far_block_error_count,
	input wire logic [15:0] tx_far_block_error_count,
	output logic [7:0] window_value
);

	logic [7:0] pick;

	always_comb
	begin
		unique case (window_select)
			4'h0: pick = crc_error_count[7:0];
			4'h1: pick = crc_error_count[15:8];
			4'h2: pick = frame_error_count[7:0];
			4'h3: pick = frame_error_count[15:8];
			4'h4: pick = alignment_change_count;
			4'h5: pick = out_of_frame_count;
			4'h6: pick = pattern_detector_count[7:0];
			4'h7: pick = pattern_detector_count[15:8];
			4'h8: pick = code_violation_count[7:0];
			4'h9: pick = code_violation_count[15:8];
			4'ha: pick = tx_crc_error_count[7:0];
			4'hb: pick = tx_crc_error_count[15:8];
			4'hc: pick = far_block_error_count[7:0];
			4'hd: pick = far_block_error_count[15:8];
			4'he: pick = tx_far_block_error_count[7:0];
			4'hf: pick = tx_far_block_error_count[15:8];
		endcase
	end

	// data byte follows the select, zero after reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			window_value <= 8'h00;
		else if (clear)
			window_value <= 8'h00;
		else
			window_value <= pick;
	end

endmodule

/* e1tx_jitter_track.sv */
`timescale 1ns/1ps
// Pointer gap indicator and near-limit bandwidth widening
module e1tx_jitter_track
	import e1tx_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clear,
	input wire logic atten_enable,
	input wire logic peak_hold,
	input wire logic widen_allowed,
	input wire logic [1:0] depth,
	input wire logic [6:0] pointer_gap,
	output logic [6:0] pointer_gap_indicator,
	output logic widened
);

	logic [7:0] size;
	logic [7:0] margin;
	logic [7:0] gap_wide;
	logic near_edge;

	always_comb
	begin
		unique case (depth)
			DEPTH_CODE_128:
			begin
				size = DEPTH_128;
				margin = MARGIN_128;
			end
			DEPTH_CODE_64:
			begin
				size = DEPTH_64;
				margin = MARGIN_64;
			end
			default:
			begin
				size = DEPTH_32;
				margin = MARGIN_32;
			end
		endcase
	end

	assign gap_wide = {1'b0, pointer_gap};
	// Close to underflow or to overflow of the chosen depth
	assign near_edge = (gap_wide < margin) || (gap_wide > size - margin);

	// live gap, peak hold keeps the larger
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pointer_gap_indicator <= RST_INDICATOR;
		else if (clear)
			pointer_gap_indicator <= RST_INDICATOR;
		else if (!peak_hold)
			pointer_gap_indicator <= pointer_gap;
		else if (pointer_gap > pointer_gap_indicator)
			pointer_gap_indicator <= pointer_gap;
	end

	// widen only inside the guard window
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			widened <= 1'b0;
		else if (clear)
			widened <= 1'b0;
		else
			widened <= atten_enable && widen_allowed && near_edge;
	end

endmodule

/* e1tx_config_chk.sv */
`timescale 1ns/1ps
// Port-level watcher for the transmit configuration register block
module e1tx_config_chk
	import e1tx_pkg::*;
#(
	parameter int ADDR_W = 10
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [6:0] tx_fifo_pointer_gap,
	input wire logic rx_backplane_muxed,
	input wire logic tx_backplane_muxed,
	input wire logic atten_enable,
	input wire logic [1:0] atten_depth,
	input wire logic atten_widen_near_limit,
	input wire logic atten_widened,
	input wire logic tx_path_power_down,
	input wire logic driver_tristate,
	input wire logic line_driver_hiz,
	input wire logic [3:0] pulse_template_sel,
	input wire logic template_arbitrary,
	input wire logic [5:0] amplitude_scale,
	input wire logic [5:0] amplitude_scale_applied
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Completing write and the two addresses whose writes the properties below check
	logic wr_done;
	assign wr_done = psel && penable && pready && pwrite;
	localparam logic [ADDR_W-1:0] A_BP = ADDR_W'({IDX_BACKPLANE, 2'b00});
	localparam logic [ADDR_W-1:0] A_SR = ADDR_W'({IDX_SOFT_RESET, 2'b00});
	property p_answer;
		psel && penable && !pready |=> pready ##1 !pready;
	endproperty
	a_answer: assert property (p_answer) else $error("answer timing wrong");
	property p_err_ready;
		pslverr |-> pready;
	endproperty
	a_err_ready: assert property (p_err_ready) else $error("error without ready");
	property p_hiz;
		1'b1 |=> line_driver_hiz == $past(tx_path_power_down | driver_tristate);
	endproperty
	a_hiz: assert property (p_hiz) else $error("driver float wrong");
	property p_arb;
		1'b1 |=> template_arbitrary == ($past(pulse_template_sel[3:2]) == TEMPLATE_ARB_TOP);
	endproperty
	a_arb: assert property (p_arb) else $error("arbitrary flag wrong");
	property p_scale;
		1'b1 |=> amplitude_scale_applied == (($past(pulse_template_sel[3:2]) == 2'h3) ?
			$past(amplitude_scale) : SCALE_STANDARD);
	endproperty
	a_scale: assert property (p_scale) else $error("applied scale wrong");
	property p_widen_off;
		!(atten_enable && atten_widen_near_limit) |=> !atten_widened;
	endproperty
	a_widen_off: assert property (p_widen_off) else $error("widened while off");
	property p_widen_on;
		atten_enable && atten_widen_near_limit && atten_depth == 2'h0
			&& tx_fifo_pointer_gap < 7'h04 && !(wr_done && paddr == A_SR) |=> atten_widened;
	endproperty
	a_widen_on: assert property (p_widen_on) else $error("no widening near edge");
	property p_backplane;
		wr_done && paddr == A_BP |=> rx_backplane_muxed == $past(pwdata[BIT_RX_MUX])
			&& tx_backplane_muxed == $past(pwdata[BIT_TX_MUX]);
	endproperty
	a_backplane: assert property (p_backplane) else $error("mux bits wrong");
	property p_soft;
		wr_done && paddr == A_SR |=> driver_tristate && !atten_enable && !tx_path_power_down
			&& amplitude_scale == RST_SCALE && pulse_template_sel == RST_TEMPLATE;
	endproperty
	a_soft: assert property (p_soft) else $error("soft reset incomplete");
	// Main scenarios reached
	c_soft: cover property (wr_done && paddr == A_SR);
	c_widen: cover property ($rose(atten_widened));
	c_arb: cover property ($rose(template_arbitrary));
endmodule

bind e1tx_config_regs e1tx_config_chk #(.ADDR_W(ADDR_W)) chk_u (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .tx_fifo_pointer_gap,
	.rx_backplane_muxed, .tx_backplane_muxed, .atten_enable, .atten_depth,
	.atten_widen_near_limit, .atten_widened, .tx_path_power_down, .driver_tristate,
	.line_driver_hiz, .pulse_template_sel, .template_arbitrary, .amplitude_scale,
	.amplitude_scale_applied);

/* test_e1_tx_line_config_regs.sv */
`timescale 1ns/1ps
// Register-level bench for the transmit configuration block
module test_e1_tx_line_config_regs
	import e1tx_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [9:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [127:0] cv;
	logic [6:0] gap;
	logic rxm, txm, aen, abw, alim, apk, awid, poff, lcode, dmon, dtri, hiz, tarb;
	logic [1:0] adep;
	logic [3:0] tsel;
	logic [5:0] scl, scla;
	int error_cnt = 0;
	int total_checks = 0;
	int i;
	logic [7:0] ri [6] = '{IDX_WINDOW_SELECT, IDX_BACKPLANE, IDX_JITTER_CFG, IDX_TX_PATH,
		IDX_TX_DRIVER, IDX_TX_SCALE};
	logic [7:0] rv [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h21};
	logic [7:0] rm [6] = '{8'h0f, 8'h09, 8'h3f, 8'h11, 8'h3f, 8'h3f};
	// Entries are config byte, expected widening, pointer gap
	logic [15:0] jt [15] = '{16'h1883, 16'h1804, 16'h18fd, 16'h187c, 16'h1a82, 16'h1a03,
		16'h1abe, 16'h1a3d, 16'h1c81, 16'h1c02, 16'h1c9f, 16'h1c1e, 16'h1e81, 16'h0801,
		16'h1001};

	e1tx_config_regs #(.ADDR_W(10)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.crc_error_count(cv[15:0]), .frame_error_count(cv[31:16]),
		.alignment_change_count(cv[39:32]), .out_of_frame_count(cv[47:40]),
		.pattern_detector_count(cv[63:48]), .code_violation_count(cv[79:64]),
		.tx_crc_error_count(cv[95:80]), .far_block_error_count(cv[111:96]),
		.tx_far_block_error_count(cv[127:112]), .tx_fifo_pointer_gap(gap),
		.rx_backplane_muxed(rxm), .tx_backplane_muxed(txm), .atten_enable(aen),
		.atten_depth(adep), .atten_bandwidth(abw), .atten_widen_near_limit(alim),
		.jitter_peak_hold_sel(apk), .atten_widened(awid), .tx_path_power_down(poff),
		.tx_line_code_sel(lcode), .driver_monitor_enable(dmon), .driver_tristate(dtri),
		.line_driver_hiz(hiz), .pulse_template_sel(tsel), .template_arbitrary(tarb),
		.amplitude_scale(scl), .amplitude_scale_applied(scla));

	// Free-running bus clock
	initial
	begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e)
		begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, s, e);
		end
	endtask

	// One bus transfer; held until ready is seen at an edge, released at that edge
	task automatic xfer(input logic [7:0] idx, input logic w, input logic [31:0] wd,
		output logic [31:0] rd, output logic er);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (n >= 20)
			chk(32'h1, 32'h0);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		xfer(idx, 1'b1, d, r, e);
	endtask

	task automatic rd_chk(input logic [7:0] idx, input logic [31:0] x);
		logic [31:0] r;
		logic e;
		xfer(idx, 1'b0, 32'h0, r, e);
		chk(r, x);
		chk({31'h0, e}, 32'h0);
	endtask

	// Lets registered outputs land before the ports are looked at
	task automatic settle;
		repeat (2) @(posedge pclk);
		#1;
	endtask

	// Cuts a hang short well beyond the expected run length
	initial
	begin
		#50000;
		error_cnt++;
		test_done;
	end

	// Test sequence
	initial
	begin
		logic [31:0] r;
		logic e;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 10'h000;
		pwdata = 32'h0;
		gap = 7'h00;
		cv = 128'hf0e1d2c3b4a5968778695a4b3c2d1e0f;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		for (i = 0; i < 6; i++)
			rd_chk(ri[i], {24'h0, rv[i]});
		settle;
		chk({24'h0, hiz, tarb, scla}, {24'h0, 2'b10, SCALE_STANDARD});
		$display("test reset values done");
		// Every select code, data read straight after
		for (i = 0; i < 16; i++)
		begin
			wr(IDX_WINDOW_SELECT, i);
			rd_chk(IDX_WINDOW_DATA, {24'h0, cv[8*i +: 8]});
		end
		wr(IDX_WINDOW_DATA, 32'hffffffff);
		rd_chk(IDX_WINDOW_DATA, {24'h0, cv[127:120]});
		$display("test counter window done");
		// All ones written; reserved bits must stay zero
		for (i = 0; i < 6; i++)
		begin
			wr(ri[i], 32'hffffffff);
			rd_chk(ri[i], {24'h0, rm[i]});
		end
		settle;
		chk({20'h0, rxm, txm, aen, adep, abw, alim, apk, poff, lcode, dmon, dtri},
			32'h00000fff);
		chk({14'h0, hiz, tarb, tsel, scl, scla}, 32'h0003ffff);
		wr(IDX_TX_DRIVER, 32'h08);
		wr(IDX_TX_PATH, 32'h0);
		settle;
		chk({24'h0, hiz, tarb, scla}, {26'h0, SCALE_STANDARD});
		wr(IDX_TX_PATH, 32'h10);
		settle;
		chk({31'h0, hiz}, 32'h1);
		xfer(8'h30, 1'b0, 32'h0, r, e);
		chk({31'h0, e}, 32'h1);
		rd_chk(IDX_SOFT_RESET, 32'h0);
		$display("test field access done");
		// Live gap, then peak hold
		wr(IDX_JITTER_CFG, 32'h0);
		@(posedge pclk) gap <= 7'h2a;
		settle;
		rd_chk(IDX_JITTER_IND, 32'h2a);
		wr(IDX_JITTER_CFG, 32'h20);
		@(posedge pclk) gap <= 7'h30;
		settle;
		@(posedge pclk) gap <= 7'h10;
		settle;
		rd_chk(IDX_JITTER_IND, 32'h30);
		for (i = 0; i < 15; i++)
		begin
			wr(IDX_JITTER_CFG, {24'h0, jt[i][15:8]});
			@(posedge pclk) gap <= jt[i][6:0];
			settle;
			chk({31'h0, awid}, {31'h0, jt[i][7]});
		end
		$display("test jitter done");
		wr(IDX_SOFT_RESET, 32'h5a);
		for (i = 0; i < 6; i++)
			rd_chk(ri[i], {24'h0, rv[i]});
		settle;
		chk({20'h0, rxm, txm, aen, adep, abw, alim, apk, poff, lcode, dmon, dtri},
			32'h00000001);
		chk({14'h0, hiz, tarb, tsel, scl, scla},
			{14'h0, 2'b10, RST_TEMPLATE, RST_SCALE, SCALE_STANDARD});
		$display("test soft reset done");
		test_done;
	end
endmodule
